// ### rtl/rsp_pkg.sv
package rsp_pkg;

  localparam int unsigned CLK_HZ    = 100000000;
  localparam int unsigned OUT_HZ_HI  = 32768;
  localparam int unsigned OUT_HZ_MID = 1024;
  localparam int unsigned OUT_HZ_LO  = 1;
  localparam int unsigned NCO_W     = 32;

  // phase increment per clk for a 2^NCO_W accumulator, rounded to nearest
  localparam logic [31:0] INC_HI  = 32'(((64'(OUT_HZ_HI) << NCO_W) + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
  localparam logic [31:0] INC_MID = 32'(((64'(OUT_HZ_MID) << NCO_W) + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));
  localparam logic [31:0] INC_LO  = 32'(((64'(OUT_HZ_LO) << NCO_W) + 64'(CLK_HZ / 2)) / 64'(CLK_HZ));

  localparam logic [3:0] MODE_WRITE   = 4'h1;
  localparam logic [3:0] MODE_READ    = 4'h9;
  localparam logic [3:0] ADDR_EXT     = 4'hD;
  localparam int unsigned SEL_LSB     = 2;
  localparam logic [1:0] SEL_32K      = 2'h0;
  localparam logic [1:0] SEL_1K       = 2'h1;
  localparam logic [1:0] SEL_1HZ      = 2'h2;
  localparam logic [1:0] SEL_GATED    = 2'h3;
  localparam logic [7:0] EXT_RESET    = 8'h0C;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  typedef enum logic [2:0] {
    RSP_IDLE,
    RSP_CMD,
    RSP_WRITE,
    RSP_READ,
    RSP_IGNORE
  } rsp_state_t;

  typedef struct packed {
    logic [1:0] ce;
    logic [2:0] sclk;
    logic [1:0] din;
    logic [1:0] oe_en;
    logic [1:0] halt;
  } rsp_sync_t;

  typedef struct packed {
    rsp_sync_t       sy;
    rsp_state_t      st;
    logic [7:0]      sh;
    logic [2:0]      cnt;
    logic [3:0]      addr;
    logic [15:0][7:0] mem;
    logic            sd_out;
    logic            sd_oe;
    logic            ck_out;
    logic            ck_oe;
  } rsp_regs_t;

endpackage

// ### rtl/rsp_nco.sv
`timescale 1ns/1ps
module rsp_nco
  import rsp_pkg::*;
#(
  parameter logic [31:0] INC = 32'h0000_0001
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      wave
);

  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;

  // fractional divider: edges jitter by one clk, mean rate follows the crystal
  always_comb
  begin
    nxt_acc = acc_ff + INC;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      acc_ff <= 32'h0000_0000;
    else
      acc_ff <= nxt_acc;
  end

  assign wave = acc_ff[31];

endmodule // rsp_nco

// ### rtl/rsp_serial_clock_out_pin.sv
`timescale 1ns/1ps
// Summary of operation
// [RQ1] select 00/01/10 drive 32768, 1024, 1 Hz push-pull whatever enable says
// [RQ2] select 11 drives 32768 Hz if enable high, else output floats
// [RQ3] reset sets both select bits, giving 32768 Hz when enable is high
// [RQ4] gating by enable pin alone only ever yields 32768 Hz
// [RQ5] clock-halt keeps 32768 and 1024 Hz but suppresses the 1 Hz choice
// [RQ6] host raises chip select, sends one byte of address and mode, then whole bytes
// [RQ7] address, mode and data shift most significant bit first
// [RQ8] address increments after each byte, wrapping F to 0
// [RQ9] chip select falling mid-byte discards the partial write byte
// [RQ10] mode code 1 selects write, 9 selects read
// [RQ11] any other mode code ignores the rest and keeps data pin floating
// [RQ12] select bits live in extension register D bits 3:2
// [RQ13] clock output derives from the on-chip clock, push-pull
// [RQ14] first byte holds address high nibble, mode low nibble
// [RQ15] data pin driven only while shifting read data
module rsp_serial_clock_out_pin
  import rsp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic chip_select,
  input  wire logic serial_clk,
  input  wire logic serial_data_in,
  output logic      serial_data_out,
  output logic      serial_data_oe,
  input  wire logic clock_out_enable_pin,
  input  wire logic clock_halt,
  output logic      clock_out_pin,
  output logic      clock_out_oe
);

  rsp_regs_t r_ff;
  rsp_regs_t nxt_r;
  logic      w_hi;
  logic      w_mid;
  logic      w_lo;
  logic      ce_s;
  logic      rise;
  logic      fall;
  logic      din_s;
  logic [7:0] byte_in;
  logic [1:0] freq_select_field;
  logic      freq_select_hi;
  logic      freq_select_lo;

  rsp_nco #(.INC(INC_HI))  u_hi  (.clk(clk), .rst(rst), .wave(w_hi)); // RQ13
  rsp_nco #(.INC(INC_MID)) u_mid (.clk(clk), .rst(rst), .wave(w_mid));
  rsp_nco #(.INC(INC_LO))  u_lo  (.clk(clk), .rst(rst), .wave(w_lo));

  // only the second sync stage and later feed logic
  assign ce_s    = r_ff.sy.ce[1];
  assign din_s   = r_ff.sy.din[1];
  assign rise    = r_ff.sy.sclk[1] & ~r_ff.sy.sclk[2];
  assign fall    = ~r_ff.sy.sclk[1] & r_ff.sy.sclk[2];
  assign byte_in = {r_ff.sh[6:0], din_s}; // RQ7
  assign freq_select_field = r_ff.mem[ADDR_EXT][SEL_LSB +: 2]; // RQ12
  assign freq_select_hi    = freq_select_field[1];
  assign freq_select_lo    = freq_select_field[0];

  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.sy.ce    = {r_ff.sy.ce[0], chip_select};
    nxt_r.sy.sclk  = {r_ff.sy.sclk[1:0], serial_clk};
    nxt_r.sy.din   = {r_ff.sy.din[0], serial_data_in};
    nxt_r.sy.oe_en = {r_ff.sy.oe_en[0], clock_out_enable_pin};
    nxt_r.sy.halt  = {r_ff.sy.halt[0], clock_halt};

    if (!ce_s)
    begin
      // a byte still in the shifter is simply dropped
      nxt_r.st     = RSP_IDLE; // RQ9
      nxt_r.cnt    = 3'h0;
      nxt_r.sd_oe  = 1'b0; // RQ15
    end
    else
    begin
      unique case (r_ff.st)
        RSP_IDLE:
        begin
          nxt_r.st  = RSP_CMD; // RQ6
          nxt_r.cnt = 3'h0;
        end
        RSP_CMD:
        begin
          if (rise)
          begin
            nxt_r.sh  = byte_in;
            nxt_r.cnt = r_ff.cnt + 3'h1;
            if (r_ff.cnt == BIT_LAST)
            begin
              nxt_r.addr = byte_in[7:4]; // RQ14
              if (byte_in[3:0] == MODE_WRITE)
                nxt_r.st = RSP_WRITE; // RQ10
              else if (byte_in[3:0] == MODE_READ)
                nxt_r.st = RSP_READ; // RQ10
              else
                nxt_r.st = RSP_IGNORE; // RQ11
            end
          end
        end
        RSP_WRITE:
        begin
          if (rise)
          begin
            nxt_r.sh  = byte_in;
            nxt_r.cnt = r_ff.cnt + 3'h1;
            if (r_ff.cnt == BIT_LAST)
            begin
              nxt_r.mem[r_ff.addr] = byte_in; // RQ6
              nxt_r.addr = r_ff.addr + 4'h1; // RQ8
            end
          end
        end
        RSP_READ:
        begin
          if (fall)
          begin
            // register read live, so each bit reflects the current value
            nxt_r.sd_out  = r_ff.mem[r_ff.addr][BIT_LAST - r_ff.cnt]; // RQ7
            nxt_r.sd_oe   = 1'b1; // RQ15
            nxt_r.cnt     = r_ff.cnt + 3'h1;
            if (r_ff.cnt == BIT_LAST)
              nxt_r.addr = r_ff.addr + 4'h1; // RQ8
          end
        end
        RSP_IGNORE:
        begin
          nxt_r.sd_oe = 1'b0; // RQ11
        end
        default:
        begin
          nxt_r.st = RSP_IDLE;
        end
      endcase
    end

    // clock output path
    nxt_r.ck_oe = 1'b1; // RQ1
    unique case (freq_select_field)
      SEL_32K:   nxt_r.ck_out = w_hi; // RQ1
      SEL_1K:    nxt_r.ck_out = w_mid; // RQ1
      SEL_1HZ:   nxt_r.ck_out = w_lo & ~r_ff.sy.halt[1]; // RQ5
      SEL_GATED:
      begin
        // pin is parked low while floated so re-enabling never glitches high
        nxt_r.ck_out = w_hi & r_ff.sy.oe_en[1]; // RQ4
        nxt_r.ck_oe  = r_ff.sy.oe_en[1]; // RQ2
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r_ff <= '0;
      r_ff.st <= RSP_IDLE;
      r_ff.mem[ADDR_EXT] <= EXT_RESET; // RQ3
    end
    else
      r_ff <= nxt_r;
  end

  assign serial_data_out = r_ff.sd_out;
  assign serial_data_oe  = r_ff.sd_oe;
  assign clock_out_pin   = r_ff.ck_out;
  assign clock_out_oe    = r_ff.ck_oe;

  sequence s_cmd_done;
    r_ff.st == RSP_CMD && ce_s && rise && r_ff.cnt == BIT_LAST;
  endsequence

  sequence s_byte_commit;
    r_ff.st == RSP_WRITE && ce_s && rise && r_ff.cnt == BIT_LAST;
  endsequence

  chk_oe_read_only: assert property (@(posedge clk) disable iff (rst) // RQ15
    serial_data_oe |-> r_ff.st == RSP_READ)
    else $error("data pin driven outside read");

  chk_ce_low_float: assert property (@(posedge clk) disable iff (rst) // RQ15
    !ce_s |=> !serial_data_oe)
    else $error("data pin driven with chip select low");

  chk_bad_mode_float: assert property (@(posedge clk) disable iff (rst) // RQ11
    s_cmd_done ##0 (byte_in[3:0] != MODE_WRITE && byte_in[3:0] != MODE_READ)
      |=> r_ff.st == RSP_IGNORE && !serial_data_oe)
    else $error("unknown mode not ignored");

  chk_write_mode: assert property (@(posedge clk) disable iff (rst) // RQ10
    s_cmd_done ##0 byte_in[3:0] == MODE_WRITE |=> r_ff.st == RSP_WRITE
      && r_ff.addr == $past(byte_in[7:4]))
    else $error("write mode not entered");

  chk_addr_wrap: assert property (@(posedge clk) disable iff (rst) // RQ8
    s_byte_commit |=> r_ff.addr == $past(r_ff.addr) + 4'h1
      && r_ff.mem[$past(r_ff.addr)] == $past(byte_in))
    else $error("write commit or increment wrong");

  chk_gated_off: assert property (@(posedge clk) disable iff (rst) // RQ2
    freq_select_field == SEL_GATED && !r_ff.sy.oe_en[1] |=> !clock_out_oe)
    else $error("clock output not floated");

  chk_always_drive: assert property (@(posedge clk) disable iff (rst) // RQ1
    freq_select_field != SEL_GATED |=> clock_out_oe)
    else $error("clock output floated for a driven select");

  chk_halt_one_hz: assert property (@(posedge clk) disable iff (rst) // RQ5
    freq_select_field == SEL_1HZ && r_ff.sy.halt[1] |=> !clock_out_pin)
    else $error("1 Hz output not suppressed by halt");

  chk_gated_on: assert property (@(posedge clk) disable iff (rst) // RQ4
    freq_select_field == SEL_GATED && r_ff.sy.oe_en[1] |=> clock_out_oe
      && clock_out_pin == $past(w_hi))
    else $error("gated output not at the fast rate");

  // a cut byte must leave the whole register file untouched
  chk_partial_drop: assert property (@(posedge clk) disable iff (rst) // RQ9
    r_ff.st == RSP_WRITE && !ce_s |=> r_ff.mem == $past(r_ff.mem))
    else $error("partial byte committed at chip select fall");

  chk_reset_select: assert property (@(posedge clk) disable iff (rst) // RQ3
    $past(rst) |-> freq_select_hi && freq_select_lo)
    else $error("select bits not set after reset");

endmodule // rsp_serial_clock_out_pin

// ### test/rsp_host.sv
`timescale 1ns/1ps
module rsp_host (
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  output logic      cs,
  output logic      sck,
  output wire logic sdi
);
  logic hdrv = 1'b0;
  logic hbit = 1'b0;
  // released line shows the inverse of the last bit, never a lucky match
  assign sdi = sdo_oe ? sdo : (hdrv ? hbit : ~hbit);
  initial
  begin
    cs = 1'b0;
    sck = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // nb data bits after the command byte; 6 clk per level keeps sync margin
  task automatic run(input logic [7:0] cmd, input logic [15:0] wd, input int nb,
                     output logic [15:0] rd);
    logic [23:0] v;
    v = {cmd, wd};
    rd = '0;
    cs = 1'b1;
    tk(4);
    for (int i = 0; i < 8 + nb; i++)
    begin
      hdrv = (i < 8) || (cmd[3:0] != 4'h9);
      hbit = v[23 - i];
      tk(6);
      rd = {rd[14:0], sdi};
      sck = 1'b1;
      tk(6);
      sck = 1'b0;
    end
    tk(6);
    cs = 1'b0;
    hdrv = 1'b0;
    tk(6);
  endtask
endmodule // rsp_host

// ### test/rsp_serial_clock_out_pin_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module rsp_serial_clock_out_pin_bench
  import rsp_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        oe_pin = 1'b1;
  logic        halt = 1'b0;
  int          oe_cnt = 0;
  logic        cs, sck, sdi, sdo, sdo_oe, ck_out, ck_oe;
  logic [15:0] rd;
  int          num_errors = 0;
  int          checked = 0;
  int          n;
  always #5 clk = ~clk;
  always @(posedge clk) if (sdo_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  rsp_host u_host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .cs(cs), .sck(sck), .sdi(sdi));
  rsp_serial_clock_out_pin u_dut (
    .clk                  (clk),
    .rst                  (rst),
    .chip_select          (cs),
    .serial_clk           (sck),
    .serial_data_in       (sdi),
    .serial_data_out      (sdo),
    .serial_data_oe       (sdo_oe),
    .clock_out_enable_pin (oe_pin),
    .clock_halt           (halt),
    .clock_out_pin        (ck_out),
    .clock_out_oe         (ck_oe)
  );
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rdb(input logic [3:0] a, input int nb);
    u_host.run({a, MODE_READ}, 16'h0000, nb, rd);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input int nb);
    u_host.run({a, MODE_WRITE}, d, nb, rd);
  endtask
  // n ends as the clk count from the call to the next rising output edge
  task automatic rise_wait;
    n = 0;
    while (ck_out !== 1'b0 && n < 9000) begin @(posedge clk); #1; n++; end
    while (ck_out !== 1'b1 && n < 9000) begin @(posedge clk); #1; n++; end
    if (n >= 9000)
    begin
      num_errors++;
      stop_test();
    end
  endtask
  initial
  begin
    u_host.tk(2);
    rst = 1'b0;
    u_host.tk(6);
    `CHK("oe_reset", 1'b1, ck_oe)
    rdb(ADDR_EXT, 8);
    `CHK("ext_reset", EXT_RESET, rd[7:0])
    rise_wait;
    rise_wait;
    `CHK("period_hi", 1'b1, n inside {[3050:3053]})
    oe_pin = 1'b0;
    u_host.tk(6);
    `CHK("oe_gated", 1'b0, ck_oe)
    $display("test reset_and_gate done");
    halt = 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      wr(ADDR_EXT, {4'h0, 2'(s), 2'h0, 8'h00}, 8);
      u_host.tk(6);
      if (s < 2)
        `CHK("oe_sel", 1'b1, ck_oe)
      else
        `CHK("halt_1hz", 1'b0, ck_out)
      if (s == 0)
      begin
        rise_wait;
        rise_wait;
        `CHK("halt_32k", 1'b1, n inside {[3050:3053]})
      end
    end
    $display("test select done");
    wr(4'hF, 16'hA55A, 16);
    rdb(4'hF, 16);
    `CHK("wrap_rd", 16'hA55A, rd)
    rdb(4'h0, 8);
    `CHK("addr0", 8'h5A, rd[7:0])
    $display("test wrap done");
    wr(4'h5, 16'hFF00, 4);
    rdb(4'h5, 8);
    `CHK("partial", 8'h00, rd[7:0])
    $display("test partial done");
    for (int c = 0; c < 16; c += 5)
    begin
      n = oe_cnt;
      u_host.run({4'h5, 4'(c)}, 16'hFF00, 8, rd);
      `CHK("bad_oe", n, oe_cnt)
    end
    rdb(4'h5, 8);
    `CHK("bad_data", 8'h00, rd[7:0])
    $display("test bad_mode done");
    rst = 1'b1;
    u_host.tk(2);
    rst = 1'b0;
    u_host.tk(6);
    rdb(ADDR_EXT, 8);
    `CHK("ext_rerun", EXT_RESET, rd[7:0])
    `CHK("oe_rerun", 1'b0, ck_oe)
    $display("test rerun_reset done");
    stop_test();
  end
endmodule // rsp_serial_clock_out_pin_bench
